// ### clock_switch.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - A control byte accepts one write only right after its valid unlock
// - Absent new source: keep old clock, switch request stays set
// - PLL sources finish only after lock; lost lock clears lock flag
// - Clearing switch request aborts, resets start-up timer, stops PLL unless current source uses it
// - Abort anytime; a fresh request restarts and aborts the earlier one
// - Sleep during a switch aborts it, keeps old clock, clears request
// - Two-speed start: power up on fast RC, auto switch when ready
// - After two-speed switch fast RC stops unless fail monitor enabled
// - Two-speed start ignores the switching and monitor mode field
// - Current and next source fields readable; equal means complete
// - Unimplemented bits read zero; reset values fixed in hex
// - Control reset depends on initial source and reset type
// - Success clears request, copies next to current, drops old source
// - Request for the current source is redundant and cleared
// - Mode 1x disables all, 01 switching only, 00 both
module clock_switch
   import clock_switch_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] source_config_word,
   input  wire logic [15:0] osc_config_word,
   input  wire logic        power_on,
   input  wire logic [7:0]  osc_ready,
   input  wire logic        pll_lock,
   input  wire logic        clock_fail,
   input  wire logic        sleep_entry,
   output logic      [7:0]  src_enable,
   output logic             pll_enable,
   output logic             startup_run,
   output logic      [2:0]  clk_sel,
   output logic             mux_hold,
   output logic             sleep_ack,
   output logic             pin_map_lock,
   output logic      [15:0] div_ctrl,
   output logic      [15:0] pll_fb_div,
   output logic      [15:0] rc_tune,
   output logic      [15:0] aux_ctrl,
   output logic             irq
);

   typedef struct packed {
      switch_state_e state;
      unlock_e       unl_hi;
      unlock_e       unl_lo;
      logic [2:0]    current_source_sel;
      logic [2:0]    next_source_sel;
      logic          switch_request;
      logic          switch_lockout;
      logic          pin_lock;
      logic          lock_flag;
      logic          clock_fail_flag;
      logic          sec_keep_on;
      logic [15:0]   clock_divider_reg;
      logic [15:0]   pllfb;
      logic [15:0]   tune;
      logic [15:0]   aux;
      logic [3:0]    int_stat;
      logic [3:0]    int_mask;
      logic [10:0]   startup_cnt;
      logic [2:0]    hold_cnt;
      logic [7:0]    rdy_s1;
      logic [7:0]    rdy_s2;
      logic          lock_s1;
      logic          lock_s2;
      logic [15:0]   cfg_sel_s1;
      logic [15:0]   cfg_sel_s2;
      logic [15:0]   cfg_osc_s1;
      logic [15:0]   cfg_osc_s2;
      logic [7:0]    src_en;
      logic          pll_en;
      logic          startup_run;
      logic [2:0]    clk_sel;
      logic          mux_hold;
      logic          sleep_ack;
      logic          irq;
      logic [31:0]   prdata;
      logic          pready;
      logic          pslverr;
   } state_s;

   state_s r_reg;
   state_s r_next;

   function automatic logic [15:0] wr16(input logic [15:0] old,
                                        input logic [15:0] data,
                                        input logic [1:0]  strb,
                                        input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (strb[0]) begin
         v[7:0] = data[7:0];
      end
      if (strb[1]) begin
         v[15:8] = data[15:8];
      end
      return v & mask;
   endfunction : wr16

   function automatic logic uses_pll(input logic [2:0] src);
      return (src == SRC_FAST_RC_PLL) || (src == SRC_PRIMARY_PLL);
   endfunction : uses_pll

   function automatic logic crystal(input logic [2:0] src);
      return (src == SRC_PRIMARY) || (src == SRC_PRIMARY_PLL) ||
             (src == SRC_SECONDARY);
   endfunction : crystal

   logic        access;
   logic        wr;
   logic        hi_wr;
   logic        lo_wr;
   logic        hi_take;
   logic        lo_take;
   logic [1:0]  mode;
   logic        switch_en;
   logic        monitor_en;
   logic        sw_allowed;
   logic        new_ready;
   logic [3:0]  ev;
   logic [3:0]  clr;
   logic [7:0]  need;
   logic [15:0] osc_word;

   always_comb begin
      r_next = r_reg;
      ev = 4'h0;
      clr = 4'h0;
      need = 8'h00;
      // Ready, lock and config inputs pass two flops before use
      r_next.rdy_s1 = osc_ready;
      r_next.rdy_s2 = r_reg.rdy_s1;
      r_next.lock_s1 = pll_lock;
      r_next.lock_s2 = r_reg.lock_s1;
      r_next.cfg_sel_s1 = source_config_word;
      r_next.cfg_sel_s2 = r_reg.cfg_sel_s1;
      r_next.cfg_osc_s1 = osc_config_word;
      r_next.cfg_osc_s2 = r_reg.cfg_osc_s1;

      mode = r_reg.cfg_osc_s2[7:6];
      switch_en = !mode[1];
      monitor_en = (mode == 2'b00);
      sw_allowed = switch_en && !(r_reg.switch_lockout && mode == 2'b01);

      access = psel && penable && r_reg.pready;
      wr = access && pwrite;
      hi_wr = wr && (paddr == OFF_OSC_CONTROL) && pstrb[1];
      lo_wr = wr && (paddr == OFF_OSC_CONTROL) && pstrb[0];
      hi_take = hi_wr && (r_reg.unl_hi == unl_open);
      lo_take = lo_wr && (r_reg.unl_lo == unl_open);

      // Any other access in between closes the window
      if (access) begin
         r_next.unl_hi = unl_idle;
         r_next.unl_lo = unl_idle;
         if (hi_wr && pwdata[15:8] == KEY_HI_FIRST) begin
            r_next.unl_hi = unl_key1;
         end else if (hi_wr && r_reg.unl_hi == unl_key1 &&
                      pwdata[15:8] == KEY_HI_SECOND) begin
            r_next.unl_hi = unl_open;
         end
         if (lo_wr && pwdata[7:0] == KEY_LO_FIRST) begin
            r_next.unl_lo = unl_key1;
         end else if (lo_wr && r_reg.unl_lo == unl_key1 &&
                      pwdata[7:0] == KEY_LO_SECOND) begin
            r_next.unl_lo = unl_open;
         end
      end

      if (hi_take && sw_allowed) begin
         r_next.next_source_sel = pwdata[10:8];
      end
      if (lo_take) begin
         r_next.sec_keep_on = pwdata[BIT_SEC_KEEP_ON];
         r_next.switch_lockout = r_reg.switch_lockout |
                                 pwdata[BIT_SW_LOCKOUT];
         if (!(r_reg.cfg_osc_s2[BIT_ONE_WAY] && r_reg.pin_lock)) begin
            r_next.pin_lock = pwdata[BIT_PIN_LOCK];
         end
         r_next.clock_fail_flag = r_reg.clock_fail_flag &
                                  pwdata[BIT_FAIL_FLAG];
      end

      // Other control registers, byte lanes honoured
      if (wr && paddr == OFF_CLOCK_DIV) begin
         r_next.clock_divider_reg = wr16(r_reg.clock_divider_reg,
                                         pwdata[15:0], pstrb[1:0],
                                         MSK_CLOCK_DIV);
      end
      if (wr && paddr == OFF_PLL_FEEDBACK) begin
         r_next.pllfb = wr16(r_reg.pllfb, pwdata[15:0], pstrb[1:0],
                             MSK_PLL_FEEDBACK);
      end
      if (wr && paddr == OFF_RC_TUNING) begin
         r_next.tune = wr16(r_reg.tune, pwdata[15:0], pstrb[1:0],
                            MSK_RC_TUNING);
      end
      if (wr && paddr == OFF_AUX_CLOCK) begin
         r_next.aux = wr16(r_reg.aux, pwdata[15:0], pstrb[1:0],
                           MSK_AUX_CLOCK);
      end
      if (wr && paddr == OFF_INT_MASK && pstrb[0]) begin
         r_next.int_mask = pwdata[3:0];
      end
      if (wr && paddr == OFF_INT_STATUS && pstrb[0]) begin
         clr = pwdata[3:0];
      end

      // Lock flag follows the synchronised lock while the PLL runs
      r_next.lock_flag = r_reg.lock_s2 && r_reg.pll_en;
      if (r_reg.lock_flag && !r_reg.lock_s2 && r_reg.pll_en) begin
         ev[EV_LOCK_LOST] = 1'b1;
      end
      new_ready = r_reg.rdy_s2[r_reg.next_source_sel] &&
                  (!crystal(r_reg.next_source_sel) ||
                   r_reg.startup_cnt == STARTUP_CYCLES) &&
                  (!uses_pll(r_reg.next_source_sel) ||
                   r_reg.lock_flag);

      unique case (r_reg.state)
         st_init: begin
            // Wait for the strap synchronisers to fill
            r_next.hold_cnt = r_reg.hold_cnt + 3'h1;
            if (r_reg.hold_cnt == SYNC_SETTLE) begin
               r_next.hold_cnt = 3'h0;
               r_next.current_source_sel = r_reg.cfg_sel_s2[2:0];
               r_next.next_source_sel = r_reg.cfg_sel_s2[2:0];
               r_next.clk_sel = r_reg.cfg_sel_s2[2:0];
               r_next.state = st_idle;
               // Mode field not consulted here on purpose
               if (power_on && r_reg.cfg_sel_s2[BIT_TWO_SPEED] &&
                   r_reg.cfg_sel_s2[2:0] != SRC_FAST_RC) begin
                  r_next.current_source_sel = SRC_FAST_RC;
                  r_next.clk_sel = SRC_FAST_RC;
                  r_next.switch_request = 1'b1;
                  r_next.state = st_start;
               end
            end
         end
         st_idle: begin
         end
         st_start: begin
            r_next.startup_cnt = 11'h000;
            if (r_reg.next_source_sel == r_reg.current_source_sel) begin
               r_next.switch_request = 1'b0;
               r_next.state = st_idle;
            end else begin
               r_next.lock_flag = 1'b0;
               r_next.clock_fail_flag = 1'b0;
               r_next.state = st_wait;
            end
         end
         st_wait: begin
            // Start-up timer counts only once the crystal oscillates
            if (crystal(r_reg.next_source_sel) &&
                r_reg.rdy_s2[r_reg.next_source_sel] &&
                r_reg.startup_cnt != STARTUP_CYCLES) begin
               r_next.startup_cnt = r_reg.startup_cnt + 11'h001;
            end
            // A source that never comes up leaves us here
            if (new_ready) begin
               r_next.mux_hold = 1'b1;
               r_next.hold_cnt = 3'h0;
               r_next.state = st_hold;
            end
         end
         st_hold: begin
            r_next.hold_cnt = r_reg.hold_cnt + 3'h1;
            if (r_reg.hold_cnt == MUX_SEL_CYCLE) begin
               r_next.clk_sel = r_reg.next_source_sel;
            end
            if (r_reg.hold_cnt == MUX_DONE_CYCLE) begin
               r_next.mux_hold = 1'b0;
               r_next.current_source_sel = r_reg.next_source_sel;
               r_next.switch_request = 1'b0;
               r_next.startup_cnt = 11'h000;
               r_next.state = st_idle;
               ev[EV_DONE] = 1'b1;
            end
         end
      endcase

      // Software abort, restart and sleep take priority over the sequence
      if (r_reg.state != st_init) begin
         if (lo_take && !pwdata[BIT_SWITCH_REQ] && r_reg.switch_request) begin
            r_next.switch_request = 1'b0;
            r_next.startup_cnt = 11'h000;
            r_next.clk_sel = r_reg.current_source_sel;
            r_next.mux_hold = 1'b0;
            r_next.state = st_idle;
            ev[EV_ABORT] = 1'b1;
         end else if (lo_take && pwdata[BIT_SWITCH_REQ] && sw_allowed) begin
            r_next.switch_request = 1'b1;
            r_next.clk_sel = r_reg.current_source_sel;
            r_next.mux_hold = 1'b0;
            r_next.state = st_start;
            if (r_reg.switch_request) begin
               ev[EV_ABORT] = 1'b1;
            end
         end
         if (sleep_entry && r_reg.switch_request) begin
            r_next.switch_request = 1'b0;
            r_next.next_source_sel = r_reg.current_source_sel;
            r_next.clk_sel = r_reg.current_source_sel;
            r_next.mux_hold = 1'b0;
            r_next.startup_cnt = 11'h000;
            r_next.state = st_idle;
            ev[EV_ABORT] = 1'b1;
         end
      end
      // Power-save proceeds one cycle later in any case
      r_next.sleep_ack = sleep_entry;

      // Fail flag: detector event beats a software clear
      if (clock_fail) begin
         r_next.clock_fail_flag = 1'b1;
         ev[EV_CLK_FAIL] = 1'b1;
      end

      // Oscillator enables: current, target while pending, and keepers
      if (r_next.state != st_init) begin
         need[r_next.current_source_sel] = 1'b1;
         if (r_next.switch_request) begin
            need[r_next.next_source_sel] = 1'b1;
         end
      end
      if (monitor_en) begin
         need[SRC_FAST_RC] = 1'b1;
         need[SRC_LOW_POWER] = 1'b1;
      end
      if (r_next.sec_keep_on) begin
         need[SRC_SECONDARY] = 1'b1;
      end
      r_next.src_en = need;
      r_next.pll_en = (r_next.state != st_init) &&
                      (uses_pll(r_next.current_source_sel) ||
                       (r_next.switch_request &&
                        uses_pll(r_next.next_source_sel)));
      r_next.startup_run = (r_next.state == st_wait) &&
                           crystal(r_next.next_source_sel);

      // Sticky events; a new event beats the clear
      r_next.int_stat = (r_reg.int_stat & ~clr) | ev;
      r_next.irq = |(r_next.int_stat & r_next.int_mask);

      // APB: data prepared in setup, ready in the access cycle
      osc_word = {1'b0, r_reg.current_source_sel, 1'b0,
                  r_reg.next_source_sel,
                  r_reg.switch_lockout, r_reg.pin_lock, r_reg.lock_flag,
                  1'b0, r_reg.clock_fail_flag, 1'b0, r_reg.sec_keep_on,
                  r_reg.switch_request};
      r_next.pready = psel && !penable && !r_reg.pready;
      // Error stands only beside its one ready cycle
      r_next.pslverr = 1'b0;
      if (psel && !penable) begin
         r_next.prdata = 32'h0000_0000;
         r_next.pslverr = 1'b0;
         unique case (paddr)
            OFF_OSC_CONTROL:  r_next.prdata[15:0] = osc_word;
            OFF_CLOCK_DIV:    r_next.prdata[15:0] = r_reg.clock_divider_reg;
            OFF_PLL_FEEDBACK: r_next.prdata[15:0] = r_reg.pllfb;
            OFF_RC_TUNING:    r_next.prdata[15:0] = r_reg.tune;
            OFF_AUX_CLOCK:    r_next.prdata[15:0] = r_reg.aux;
            OFF_SOURCE_CFG:   r_next.prdata[15:0] = r_reg.cfg_sel_s2;
            OFF_OSC_CFG:      r_next.prdata[15:0] = r_reg.cfg_osc_s2;
            OFF_INT_STATUS:   r_next.prdata[3:0] = r_reg.int_stat;
            OFF_INT_MASK:     r_next.prdata[3:0] = r_reg.int_mask;
            default:          r_next.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.state <= st_init;
         r_reg.current_source_sel <= RST_OSC_CONTROL[14:12];
         r_reg.next_source_sel <= RST_OSC_CONTROL[10:8];
         r_reg.clk_sel <= RST_OSC_CONTROL[14:12];
         r_reg.clock_divider_reg <= RST_CLOCK_DIV;
         r_reg.pllfb <= RST_PLL_FEEDBACK;
         r_reg.tune <= RST_RC_TUNING;
         r_reg.aux <= RST_AUX_CLOCK;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata       = r_reg.prdata;
   assign pready       = r_reg.pready;
   assign pslverr      = r_reg.pslverr;
   assign src_enable   = r_reg.src_en;
   assign pll_enable   = r_reg.pll_en;
   assign startup_run  = r_reg.startup_run;
   assign clk_sel      = r_reg.clk_sel;
   assign mux_hold     = r_reg.mux_hold;
   assign sleep_ack    = r_reg.sleep_ack;
   assign pin_map_lock = r_reg.pin_lock;
   assign div_ctrl     = r_reg.clock_divider_reg;
   assign pll_fb_div   = r_reg.pllfb;
   assign rc_tune      = r_reg.tune;
   assign aux_ctrl     = r_reg.aux;
   assign irq          = r_reg.irq;

endmodule : clock_switch

// ### clock_switch_pkg.sv
package clock_switch_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] OFF_OSC_CONTROL  = 8'h00;
   localparam logic [7:0] OFF_CLOCK_DIV    = 8'h04;
   localparam logic [7:0] OFF_PLL_FEEDBACK = 8'h08;
   localparam logic [7:0] OFF_RC_TUNING    = 8'h0C;
   localparam logic [7:0] OFF_AUX_CLOCK    = 8'h10;
   localparam logic [7:0] OFF_SOURCE_CFG   = 8'h14;
   localparam logic [7:0] OFF_OSC_CFG      = 8'h18;
   localparam logic [7:0] OFF_INT_STATUS   = 8'h1C;
   localparam logic [7:0] OFF_INT_MASK     = 8'h20;

   // Reset values and implemented-bit masks
   localparam logic [15:0] RST_OSC_CONTROL  = 16'h7700;
   localparam logic [15:0] RST_CLOCK_DIV    = 16'h3040;
   localparam logic [15:0] RST_PLL_FEEDBACK = 16'h0030;
   localparam logic [15:0] RST_RC_TUNING    = 16'h0000;
   localparam logic [15:0] RST_AUX_CLOCK    = 16'h0000;
   localparam logic [15:0] MSK_CLOCK_DIV    = 16'hFFDF;
   localparam logic [15:0] MSK_PLL_FEEDBACK = 16'h01FF;
   localparam logic [15:0] MSK_RC_TUNING    = 16'h003F;
   localparam logic [15:0] MSK_AUX_CLOCK    = 16'h3F80;

   // Unlock keys
   localparam logic [7:0] KEY_HI_FIRST  = 8'h78;
   localparam logic [7:0] KEY_HI_SECOND = 8'h9A;
   localparam logic [7:0] KEY_LO_FIRST  = 8'h46;
   localparam logic [7:0] KEY_LO_SECOND = 8'h57;

   // Control word and config word bit positions
   localparam int BIT_SWITCH_REQ  = 0;
   localparam int BIT_SEC_KEEP_ON = 1;
   localparam int BIT_FAIL_FLAG   = 3;
   localparam int BIT_PLL_LOCK    = 5;
   localparam int BIT_PIN_LOCK    = 6;
   localparam int BIT_SW_LOCKOUT  = 7;
   localparam int BIT_TWO_SPEED   = 7;
   localparam int BIT_ONE_WAY     = 5;

   // Source codes
   localparam logic [2:0] SRC_FAST_RC     = 3'h0;
   localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRIMARY     = 3'h2;
   localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
   localparam logic [2:0] SRC_SECONDARY   = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER   = 3'h5;

   // Cycle counts
   localparam logic [10:0] STARTUP_CYCLES  = 11'h400;
   localparam logic [2:0]  MUX_SEL_CYCLE   = 3'h1;
   localparam logic [2:0]  MUX_DONE_CYCLE  = 3'h3;
   localparam logic [2:0]  SYNC_SETTLE     = 3'h2;

   // Interrupt event bits
   localparam int EV_DONE      = 0;
   localparam int EV_ABORT     = 1;
   localparam int EV_LOCK_LOST = 2;
   localparam int EV_CLK_FAIL  = 3;

   typedef enum logic [2:0] {
      st_init, st_idle, st_start, st_wait, st_hold
   } switch_state_e;

   typedef enum logic [1:0] {
      unl_idle, unl_key1, unl_open
   } unlock_e;

endpackage : clock_switch_pkg

// ### clock_switch_props.sv
`timescale 1ns/1ps
module clock_switch_props (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] osc_config_word,
   input wire logic        sleep_entry,
   input wire logic [7:0]  src_enable,
   input wire logic [2:0]  clk_sel,
   input wire logic        mux_hold,
   input wire logic        sleep_ack
);
   // Counts past init so the reset-time select jump is not judged
   logic [3:0] up_reg;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         up_reg <= 4'h0;
      else if (up_reg != 4'hF)
         up_reg <= up_reg + 4'h1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence held_four;
      mux_hold [*4] ##1 !mux_hold;
   endsequence
   sequence sel_moves;
      $stable(clk_sel) ##1 $stable(clk_sel) ##1 $changed(clk_sel);
   endsequence
   AST_HOLD_FOUR: assert property ($rose(mux_hold) |-> held_four)
      else $error("mux hold not four cycles");
   AST_SEL_STEP: assert property ($rose(mux_hold) |-> sel_moves)
      else $error("select did not move in third held cycle");
   AST_SEL_HELD: assert property (up_reg == 4'hF && $changed(clk_sel)
      |-> mux_hold)
      else $error("select changed while mux not held");
   AST_SLEEP_ACK: assert property (sleep_entry |=> sleep_ack ##1 !sleep_ack)
      else $error("sleep acknowledge wrong");
   AST_MONITOR_RC: assert property (up_reg == 4'hF
      && osc_config_word[7:6] == 2'h0 |-> src_enable[0] && src_enable[5])
      else $error("monitor mode dropped an rc source");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule : clock_switch_props

bind clock_switch clock_switch_props clock_switch_props_i (
   .sys_clk(sys_clk), .resetn(resetn), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .osc_config_word(osc_config_word),
   .sleep_entry(sleep_entry), .src_enable(src_enable), .clk_sel(clk_sel),
   .mux_hold(mux_hold), .sleep_ack(sleep_ack));

// ### clock_switch_test.sv
`timescale 1ns/1ps
module clock_switch_test;
   import clock_switch_pkg::*;
   logic        sys_clk = 1'h0, resetn = 1'h0, power_on = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        pll_lock = 1'h0, sleep_entry = 1'h0;
   logic [7:0]  paddr = 8'h00, osc_ready = 8'hEF;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic [3:0]  pstrb = 4'h0;
   logic [15:0] source_config_word = 16'h0, osc_config_word = 16'h0;
   logic        pready, pslverr, ev, pll_enable, startup_run, mux_hold;
   logic        sleep_ack, irq;
   logic [7:0]  src_enable;
   logic [2:0]  clk_sel;
   int          err_count = 0, checks_done = 0, cycles = 0;
   logic [7:0]  roff [4] = '{OFF_CLOCK_DIV, OFF_PLL_FEEDBACK, OFF_RC_TUNING,
                             OFF_AUX_CLOCK};
   logic [15:0] rval [4] = '{RST_CLOCK_DIV, RST_PLL_FEEDBACK, RST_RC_TUNING,
                             RST_AUX_CLOCK};

   clock_switch clock_switch_i (
      .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .source_config_word(source_config_word),
      .osc_config_word(osc_config_word), .power_on(power_on),
      .osc_ready(osc_ready), .pll_lock(pll_lock), .clock_fail(1'h0),
      .sleep_entry(sleep_entry), .src_enable(src_enable),
      .pll_enable(pll_enable), .startup_run(startup_run),
      .clk_sel(clk_sel), .mux_hold(mux_hold), .sleep_ack(sleep_ack),
      .pin_map_lock(), .div_ctrl(), .pll_fb_div(), .rc_tune(),
      .aux_ctrl(), .irq(irq));

   always #20 sys_clk = ~sys_clk;

   task stop_test;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Idle cycle at the end keeps psel from being assigned twice per step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
      int n;
      n = 0;
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      pstrb  <= s;
      @(posedge sys_clk);
      penable <= 1'h1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rv = prdata;
      ev = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge sys_clk);
   endtask : apb

   task rd(input logic [7:0] a);
      apb(1'h0, a, 32'h0, 4'h0);
   endtask : rd

   task wrb(input logic hi, input logic [7:0] b);
      apb(1'h1, OFF_OSC_CONTROL, hi ? {16'h0, b, 8'h0} : {24'h0, b},
          {2'h0, hi, !hi});
   endtask : wrb

   task ctl(input logic hi, input logic [7:0] v);
      wrb(hi, hi ? KEY_HI_FIRST : KEY_LO_FIRST);
      wrb(hi, hi ? KEY_HI_SECOND : KEY_LO_SECOND);
      wrb(hi, v);
   endtask : ctl

   task sw(input logic [2:0] x);
      ctl(1'h1, {5'h0, x});
      ctl(1'h0, 8'h01);
   endtask : sw

   task wait_done;
      int n;
      n = 0;
      do begin
         rd(OFF_OSC_CONTROL);
         n++;
      end while (rv[0] !== 1'h0 && n < 600);
   endtask : wait_done

   function logic [31:0] cv(input logic [2:0] c, input logic [2:0] x,
                            input logic l, input logic q);
      return {17'h0, c, 1'h0, x, 2'h0, l, 4'h0, q};
   endfunction : cv

   task rst(input logic [15:0] sc, input logic [15:0] oc, input logic po);
      resetn             <= 1'h0;
      source_config_word <= sc;
      osc_config_word    <= oc;
      power_on           <= po;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'h1;
      repeat (8) @(posedge sys_clk);
   endtask : rst

   task t_regs;
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h2, 3'h2, 1'h0, 1'h0));
      foreach (roff[i]) begin
         rd(roff[i]);
         chk(rv, {16'h0, rval[i]});
      end
      apb(1'h1, OFF_RC_TUNING, 32'hFFFFFFFF, 4'hF);
      rd(OFF_RC_TUNING);
      chk(rv, {16'h0, MSK_RC_TUNING});
      apb(1'h1, OFF_SOURCE_CFG, 32'hFFFF, 4'hF);
      rd(OFF_SOURCE_CFG);
      chk(rv, 32'h0002);
      rd(8'h40);
      chk({rv[30:0], ev}, 32'h1);
   endtask : t_regs

   task t_unlock;
      wrb(1'h1, 8'h04);
      wrb(1'h1, KEY_HI_FIRST);
      wrb(1'h1, KEY_HI_SECOND);
      rd(OFF_INT_MASK);
      wrb(1'h1, 8'h04);
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h2, 3'h2, 1'h0, 1'h0));
      ctl(1'h1, 8'h04);
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h2, 3'h4, 1'h0, 1'h0));
   endtask : t_unlock

   task t_switch;
      sw(3'h0);
      wait_done();
      chk(rv, cv(3'h0, 3'h0, 1'h0, 1'h0));
      chk(32'(src_enable[2]), 32'h0);
      rd(OFF_INT_STATUS);
      chk(rv, 32'h1);
      chk(32'(irq), 32'h0);
      apb(1'h1, OFF_INT_MASK, 32'h1, 4'hF);
      @(posedge sys_clk);
      chk(32'(irq), 32'h1);
      apb(1'h1, OFF_INT_STATUS, 32'h1, 4'hF);
      @(posedge sys_clk);
      chk(32'(irq), 32'h0);
      sw(3'h0);
      repeat (3) @(posedge sys_clk);
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h0, 3'h0, 1'h0, 1'h0));
   endtask : t_switch

   task t_abort;
      apb(1'h1, OFF_INT_STATUS, 32'hF, 4'hF);
      sw(3'h4);
      repeat (50) @(posedge sys_clk);
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h0, 3'h4, 1'h0, 1'h1));
      chk(32'(clk_sel), 32'h0);
      ctl(1'h0, 8'h00);
      repeat (3) @(posedge sys_clk);
      rd(OFF_OSC_CONTROL);
      chk(rv & 32'h7001, 32'h0);
      chk(32'({startup_run, pll_enable}), 32'h0);
      rd(OFF_INT_STATUS);
      chk(rv, 32'h2);
   endtask : t_abort

   task t_second;
      apb(1'h1, OFF_INT_STATUS, 32'hF, 4'hF);
      sw(3'h4);
      repeat (10) @(posedge sys_clk);
      // Re-request while pending restarts and flags the abort
      ctl(1'h0, 8'h01);
      sw(3'h5);
      wait_done();
      chk(rv, cv(3'h5, 3'h5, 1'h0, 1'h0));
      rd(OFF_INT_STATUS);
      chk(rv & 32'h3, 32'h3);
   endtask : t_second

   task t_sleep;
      sw(3'h4);
      repeat (10) @(posedge sys_clk);
      sleep_entry <= 1'h1;
      @(posedge sys_clk);
      sleep_entry <= 1'h0;
      repeat (3) @(posedge sys_clk);
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h5, 3'h5, 1'h0, 1'h0));
   endtask : t_sleep

   task t_pll;
      sw(3'h1);
      repeat (40) @(posedge sys_clk);
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h5, 3'h1, 1'h0, 1'h1));
      chk(32'(pll_enable), 32'h1);
      pll_lock <= 1'h1;
      wait_done();
      chk(rv, cv(3'h1, 3'h1, 1'h1, 1'h0));
   endtask : t_pll

   // Mode 1x: switching refused, yet two-speed start must still run
   task t_two_speed;
      rst(16'h0082, 16'h0080, 1'h1);
      chk(32'(clk_sel), 32'h0);
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h0, 3'h2, 1'h0, 1'h1));
      wait_done();
      chk(rv, cv(3'h2, 3'h2, 1'h0, 1'h0));
      chk(32'(src_enable[0]), 32'h0);
      sw(3'h0);
      repeat (3) @(posedge sys_clk);
      rd(OFF_OSC_CONTROL);
      chk(rv, cv(3'h2, 3'h2, 1'h0, 1'h0));
   endtask : t_two_speed

   initial begin
      rst(16'h0002, 16'h0000, 1'h0);
      t_regs();
      t_unlock();
      t_switch();
      t_abort();
      t_second();
      t_sleep();
      t_pll();
      t_two_speed();
      stop_test();
   end
endmodule : clock_switch_test
